// ===== srh_params.svh
// constants for the serial register-access host: codes, field positions and timing
`ifndef SRH_PARAMS_SVH
`define SRH_PARAMS_SVH

// ----------------------------------------------------------------
// frame encoding
// ----------------------------------------------------------------
`define SRH_CMD_READ 8'h0b
`define SRH_CMD_WRITE 8'h02
`define SRH_ADDR_W 14
`define SRH_DIR_HI 15
`define SRH_DIR_LO 14
`define SRH_DIR_INC 2'h0
`define SRH_DIR_RSVD 2'h1
`define SRH_DIR_DEC 2'h2
`define SRH_DIR_STATIC 2'h3
`define SRH_DUMMY_BYTE 8'h00
`define SRH_TEST_ADDR 14'h0000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SRH_CLK_NS 40
`define SRH_SCK_HALF_NS 120
`define SRH_SCK_HALF_CYC (`SRH_SCK_HALF_NS / `SRH_CLK_NS)
`define SRH_CS_IDLE_NS 50
`define SRH_CS_IDLE_CYC ((`SRH_CS_IDLE_NS + `SRH_CLK_NS - 1) / `SRH_CLK_NS)

`endif

// ===== srh_pkg.sv
// types shared by the serial register-access host
`include "srh_params.svh"
package srh_pkg;
    typedef struct packed {
        logic write;
        logic mode3;
        logic [1:0] dir;
        logic [`SRH_ADDR_W-1:0] addr;
        logic [7:0] len;
    } srh_req_t;

    typedef enum logic [3:0] {
        ST_BOOT,
        ST_IDLE,
        ST_SETUP,
        ST_INSTR,
        ST_ADDR_HI,
        ST_ADDR_LO,
        ST_DUMMY,
        ST_DATA,
        ST_END,
        ST_GAP
    } srh_state_t;
endpackage

// ===== srh_byte_engine.sv
// one-byte shifter: makes the serial clock, launches and samples one byte
`include "srh_params.svh"
module srh_byte_engine (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [7:0] tx,
    input wire logic mode3,
    input wire logic miso_pin,
    output logic sclk,
    output logic mosi,
    output logic busy,
    output logic done,
    output logic [7:0] rx
);
    import srh_pkg::*;

    logic miso_q1, miso_q2;
    logic hi, next_hi, next_sclk, next_mosi, next_busy, next_done;
    logic [1:0] ph, next_ph;
    logic [2:0] bit_cnt, next_bit_cnt;
    logic [7:0] sh, next_sh, next_rx;

    // ----------------------------------------------------------------
    // bit sequencing
    // ----------------------------------------------------------------
    // each bit is a low half then a high half, so mode 0 and mode 3 share
    // one sequence and differ only in the level left between bytes
    always_comb begin
        next_hi = hi;
        next_sclk = sclk;
        next_mosi = mosi;
        next_busy = busy;
        next_done = 1'b0;
        next_ph = ph;
        next_bit_cnt = bit_cnt;
        next_sh = sh;
        next_rx = rx;
        if (!busy) begin
            next_sclk = mode3;
            if (start) begin
                next_busy = 1'b1;
                next_sh = tx;
                next_mosi = tx[7];
                next_sclk = 1'b0;
                next_hi = 1'b0;
                next_ph = 2'h0;
                next_bit_cnt = 3'h0;
            end
        end else if (ph == 2'(`SRH_SCK_HALF_CYC - 1)) begin
            next_ph = 2'h0;
            if (!hi) begin
                next_hi = 1'b1;
                next_sclk = 1'b1;
            end else begin
                // sampled at the end of the high half: the synchroniser
                // delay still lands inside the bit the slave launched
                next_sh = {sh[6:0], miso_q2};
                next_hi = 1'b0;
                if (bit_cnt == 3'h7) begin
                    next_busy = 1'b0;
                    next_done = 1'b1;
                    next_rx = {sh[6:0], miso_q2};
                    next_sclk = mode3;
                end else begin
                    next_bit_cnt = bit_cnt + 3'h1;
                    next_sclk = 1'b0;
                    next_mosi = sh[6];
                end
            end
        end else begin
            next_ph = ph + 2'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            miso_q1 <= 1'b1;
            miso_q2 <= 1'b1;
            hi <= 1'b0;
            sclk <= 1'b0;
            mosi <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            ph <= 2'h0;
            bit_cnt <= 3'h0;
            sh <= 8'h00;
            rx <= 8'h00;
        end else begin
            miso_q1 <= miso_pin;
            miso_q2 <= miso_q1;
            hi <= next_hi;
            sclk <= next_sclk;
            mosi <= next_mosi;
            busy <= next_busy;
            done <= next_done;
            ph <= next_ph;
            bit_cnt <= next_bit_cnt;
            sh <= next_sh;
            rx <= next_rx;
        end
    end
endmodule

// ===== srh_host.sv
// serial master that reads and writes the device registers over one data lane
//
// Summary of operation
// - frame spans select low; clock idles low or high at select edges.
// - every frame opens with an eight-bit instruction byte.
// - two address bytes follow: 14-bit byte address, bits 15:14 direction.
// - reads carry one dummy byte of eight clocks after the address.
// - data follows dummy for reads, address for writes; one or more bytes.
// - msb first within bytes, address high byte first.
// - select stays high at least 50 ns between frames.
// - only codes 0Bh read and 02h write are ever sent.
// - single lane, serial clock no faster than 25 MHz.
// - first access after initialization is a throwaway test-register read.
`include "srh_params.svh"
module srh_host #(
    parameter logic [`SRH_ADDR_W-1:0] TEST_ADDR = `SRH_TEST_ADDR
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic req_valid,
    output logic req_ready,
    input srh_pkg::srh_req_t req,
    input wire logic wdata_valid,
    output logic wdata_ready,
    input wire logic [7:0] wdata,
    output logic rdata_valid,
    output logic [7:0] rdata,
    output logic boot_done,
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_mosi,
    input wire logic spi_miso
);
    import srh_pkg::*;

    srh_state_t state, next_state;
    srh_req_t cur, next_cur;
    logic inflight, next_inflight;
    logic is_boot, next_is_boot;
    logic cs_n, next_cs_n;
    logic next_boot_done, next_rdata_valid;
    logic [7:0] next_rdata;
    logic [7:0] cnt, next_cnt;
    logic [1:0] gap, next_gap;
    logic eng_start, eng_busy, eng_done;
    logic [7:0] eng_tx, eng_rx;

    // ----------------------------------------------------------------
    // header bytes
    // ----------------------------------------------------------------
    function automatic logic [7:0] header_byte(input srh_state_t st, input srh_req_t r);
        logic [7:0] b;
        b = `SRH_DUMMY_BYTE;
        case (st)
            ST_INSTR: b = r.write ? `SRH_CMD_WRITE : `SRH_CMD_READ;
            ST_ADDR_HI: b = {r.dir, r.addr[`SRH_ADDR_W-1:8]};
            ST_ADDR_LO: b = r.addr[7:0];
            default: b = `SRH_DUMMY_BYTE;
        endcase
        return b;
    endfunction

    function automatic srh_state_t after_header(input srh_state_t st, input srh_req_t r);
        srh_state_t n;
        n = ST_DATA;
        case (st)
            ST_INSTR: n = ST_ADDR_HI;
            ST_ADDR_HI: n = ST_ADDR_LO;
            ST_ADDR_LO: n = r.write ? ST_DATA : ST_DUMMY;
            default: n = ST_DATA;
        endcase
        return n;
    endfunction

    // ----------------------------------------------------------------
    // frame sequencing
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_cur = cur;
        next_inflight = inflight;
        next_is_boot = is_boot;
        next_cs_n = cs_n;
        next_boot_done = boot_done;
        next_rdata_valid = 1'b0;
        next_rdata = rdata;
        next_cnt = cnt;
        next_gap = gap;
        eng_start = 1'b0;
        eng_tx = `SRH_DUMMY_BYTE;
        req_ready = 1'b0;
        wdata_ready = 1'b0;
        case (state)
            ST_BOOT: begin
                // one throwaway read before any user traffic
                next_cur.write = 1'b0;
                next_cur.mode3 = 1'b0;
                next_cur.dir = `SRH_DIR_STATIC;
                next_cur.addr = TEST_ADDR;
                next_cur.len = 8'h00;
                next_cnt = 8'h00;
                next_is_boot = 1'b1;
                next_state = ST_SETUP;
            end
            ST_IDLE: begin
                req_ready = 1'b1;
                if (req_valid) begin
                    next_cur = req;
                    next_cnt = req.len;
                    next_is_boot = 1'b0;
                    next_state = ST_SETUP;
                end
            end
            ST_SETUP: begin
                // a mode change moves the clock to its new idle level first;
                // select waits for that so the two never share an edge
                if (!eng_busy && spi_sclk == cur.mode3) begin
                    next_cs_n = 1'b0;
                    next_state = ST_INSTR;
                end
            end
            ST_INSTR, ST_ADDR_HI, ST_ADDR_LO, ST_DUMMY: begin
                eng_tx = header_byte(state, cur);
                if (!inflight) begin
                    eng_start = 1'b1;
                    next_inflight = 1'b1;
                end else if (eng_done) begin
                    next_inflight = 1'b0;
                    next_state = after_header(state, cur);
                end
            end
            ST_DATA: begin
                if (!inflight) begin
                    if (cur.write) begin
                        // clocks pause with select low until data arrives
                        wdata_ready = 1'b1;
                        eng_tx = wdata;
                        if (wdata_valid) begin
                            eng_start = 1'b1;
                            next_inflight = 1'b1;
                        end
                    end else begin
                        eng_start = 1'b1;
                        next_inflight = 1'b1;
                    end
                end else if (eng_done) begin
                    next_inflight = 1'b0;
                    if (!cur.write && !is_boot) begin
                        next_rdata = eng_rx;
                        next_rdata_valid = 1'b1;
                    end
                    if (cnt == 8'h00) begin
                        next_state = ST_END;
                    end else begin
                        next_cnt = cnt - 8'h01;
                    end
                end
            end
            ST_END: begin
                // select rises only after whole bytes, so no register is torn
                next_cs_n = 1'b1;
                next_gap = 2'h0;
                next_state = ST_GAP;
            end
            ST_GAP: begin
                if (gap == 2'(`SRH_CS_IDLE_CYC - 1)) begin
                    if (is_boot) begin
                        next_boot_done = 1'b1;
                    end
                    next_state = ST_IDLE;
                end else begin
                    next_gap = gap + 2'h1;
                end
            end
            default: begin
                next_cs_n = 1'b1;
                next_inflight = 1'b0;
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_BOOT;
            cur <= '0;
            inflight <= 1'b0;
            is_boot <= 1'b0;
            cs_n <= 1'b1;
            boot_done <= 1'b0;
            rdata_valid <= 1'b0;
            rdata <= 8'h00;
            cnt <= 8'h00;
            gap <= 2'h0;
        end else begin
            state <= next_state;
            cur <= next_cur;
            inflight <= next_inflight;
            is_boot <= next_is_boot;
            cs_n <= next_cs_n;
            boot_done <= next_boot_done;
            rdata_valid <= next_rdata_valid;
            rdata <= next_rdata;
            cnt <= next_cnt;
            gap <= next_gap;
        end
    end

    assign spi_cs_n = cs_n;

    // ----------------------------------------------------------------
    // bit engine: clock is clk divided by six, two half periods of three cycles each, well under 25 MHz
    // ----------------------------------------------------------------
    srh_byte_engine u_engine (
        .clk(clk),
        .rst_n(rst_n),
        .start(eng_start),
        .tx(eng_tx),
        .mode3(cur.mode3),
        .miso_pin(spi_miso),
        .sclk(spi_sclk),
        .mosi(spi_mosi),
        .busy(eng_busy),
        .done(eng_done),
        .rx(eng_rx)
    );
endmodule

// ===== srh_host_properties.sv
// port assertions for the serial register-access host
module srh_host_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire logic req_ready,
    input srh_pkg::srh_req_t req,
    input wire logic wdata_valid,
    input wire logic wdata_ready,
    input wire logic [7:0] wdata,
    input wire logic rdata_valid,
    input wire logic [7:0] rdata,
    input wire logic boot_done,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    input wire logic spi_miso
);
    import srh_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------------------------------
    // frame and link rules
    // ----------------------------------------------------------------
    a_cs_gap: assert property ($rose(spi_cs_n) |=> spi_cs_n [*3])
        else $error("select high for fewer than four cycles");
    a_cs_edge_idle: assert property ($changed(spi_cs_n) |-> $stable(spi_sclk))
        else $error("serial clock moved at a select edge");
    a_sclk_high: assert property ($rose(spi_sclk) && !spi_cs_n && !$past(spi_cs_n) |=>
        spi_sclk [*2]) else $error("serial clock high phase too short");
    a_mosi_setup: assert property ($rose(spi_sclk) && !spi_cs_n |-> $stable(spi_mosi))
        else $error("data out changed at rising serial clock");
    a_take_frame: assert property (req_valid && req_ready |-> ##[1:3] $fell(spi_cs_n))
        else $error("taken request did not open a frame");
    a_take_busy: assert property (req_valid && req_ready |=> !req_ready)
        else $error("request ready stayed high after take");
    a_boot_gate: assert property (!boot_done |-> !req_ready)
        else $error("request ready before the test read finished");
    a_ready_idle: assert property (req_ready |-> spi_cs_n)
        else $error("request ready inside a frame");
    a_wready_frame: assert property (wdata_ready |-> !spi_cs_n)
        else $error("write data ready outside a frame");
    a_wready_gap: assert property (wdata_valid && wdata_ready |=> !wdata_ready [*8])
        else $error("next write byte taken before the byte was shifted");
    a_rd_pulse: assert property (rdata_valid |=> !rdata_valid)
        else $error("read data valid longer than one cycle");
    a_rd_in_frame: assert property (rdata_valid |-> !$past(spi_cs_n))
        else $error("read byte reported without a frame");
endmodule

bind srh_host srh_host_properties chk (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .wdata_valid(wdata_valid), .wdata_ready(wdata_ready),
    .wdata(wdata), .rdata_valid(rdata_valid), .rdata(rdata), .boot_done(boot_done),
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso));

// ===== srh_dev_model.sv
// behavioural device: byte register file behind the serial slave port
module srh_dev_model (
    input wire logic init_ok,
    input wire logic evt,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    output logic miso
);
    logic [7:0] mem [0:16383];
    logic [7:0] sh, hold, cmd, frame_bits;
    logic [13:0] ptr;
    logic [1:0] dir;
    logic armed, drive, obit;
    // one clear-on-read status byte; bit 0 is set by a hardware event
    localparam logic [13:0] COR_ADDR = 14'h2000;
    logic cor_pend, evt_pend;
    int cnt;
    // ----------------------------------------------------------------
    // slave behaviour
    // ----------------------------------------------------------------
    function automatic logic [13:0] step(input logic [13:0] a, input logic [1:0] d);
        return d == 2'h2 ? a - 14'h1 : (d == 2'h3 ? a : a + 14'h1);
    endfunction
    initial begin
        {armed, drive, obit, cor_pend, evt_pend, cnt, sh, hold, cmd, frame_bits, ptr, dir} = '0;
        for (int i = 0; i < 16384; i++) mem[i] = 8'(i) ^ 8'h5a;
    end
    // pins stay ignored until initialized and select has risen once
    always @(posedge cs_n) begin
        if (init_ok) armed = 1'b1;
        frame_bits = 8'(cnt);
        drive = 1'b0;
        if (evt_pend) mem[COR_ADDR] = mem[COR_ADDR] | 8'h01;
        {cor_pend, evt_pend} = 2'b00; // a cut read drops the clear
    end
    // an event during a clear-on-read waits until the clear is done
    always @(posedge evt) begin
        if (cor_pend) evt_pend = 1'b1;
        else mem[COR_ADDR] = mem[COR_ADDR] | 8'h01;
    end
    always @(negedge cs_n) cnt = 0;
    always @(posedge sclk) begin
        if (!cs_n && armed) begin
            sh = {sh[6:0], mosi};
            cnt++;
            if (cnt % 8 == 0) begin
                case (cnt / 8)
                    1: cmd = sh;
                    2: {dir, ptr[13:8]} = sh;
                    3: ptr[7:0] = sh;
                    default: if (cmd == 8'h02) begin
                        mem[ptr] = sh; // whole byte commits at once
                        ptr = step(ptr, dir);
                    end else if (cmd == 8'h0b) begin
                        if (cor_pend) begin
                            // clear only once the whole byte went out
                            mem[COR_ADDR] = evt_pend ? 8'h01 : 8'h00;
                            {cor_pend, evt_pend} = 2'b00;
                        end
                        if (cnt > 32) ptr = step(ptr, dir);
                        hold = mem[ptr];
                        cor_pend = (ptr == COR_ADDR);
                        drive = 1'b1;
                    end
                endcase
            end
        end
    end
    always @(negedge sclk) if (!cs_n && drive) obit = hold[7 - cnt % 8];
    // pull-up on the line whenever the slave floats it
    assign miso = (!cs_n && drive) ? obit : 1'b1;
endmodule

// ===== tb.sv
// self-checking bench: host against the behavioural device
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import srh_pkg::*;
    logic clk = 0, rst_n = 0, req_valid = 0, wdata_valid = 0, init_ok = 0, evt = 0;
    srh_req_t req = '0;
    logic [7:0] wdata = 8'h00;
    logic req_ready, wdata_ready, rdata_valid, boot_done, spi_sclk, spi_cs_n, spi_mosi, spi_miso;
    logic [7:0] rdata;
    logic [7:0] rb [3];
    logic [7:0] wb [3] = '{8'hc1, 8'h3c, 8'h96};
    int err_count = 0, checked = 0;
    always #20 clk = ~clk;
    srh_host dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
        .req(req), .wdata_valid(wdata_valid), .wdata_ready(wdata_ready), .wdata(wdata),
        .rdata_valid(rdata_valid), .rdata(rdata), .boot_done(boot_done), .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso));
    srh_dev_model dev (.init_ok(init_ok), .evt(evt), .sclk(spi_sclk), .cs_n(spi_cs_n),
        .mosi(spi_mosi), .miso(spi_miso));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick;
        @(posedge clk);
        #2;
    endtask
    // one whole frame; the request is held until the edge that takes it
    task automatic xfer(input logic w, input logic m3, input logic [1:0] d,
            input logic [13:0] a, input int n);
        tick();
        req = '{w, m3, d, a, 8'(n - 1)};
        req_valid = 1;
        while (req_ready !== 1'b1) tick();
        tick();
        req_valid = 0;
        for (int i = 0; i < n; i++) begin
            if (w) begin
                wdata = wb[i];
                wdata_valid = 1;
                while (wdata_ready !== 1'b1) tick();
                tick();
            end else begin
                tick();
                while (rdata_valid !== 1'b1) tick();
                rb[i] = rdata;
            end
        end
        wdata_valid = 0;
        while (req_ready !== 1'b1) tick();
    endtask
    task automatic report_and_stop;
        $display("checked=%0d err_count=%0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    // device comes up in the middle of the host's own test read
    task automatic t_boot;
        repeat (50) tick();
        init_ok = 1;
        while (boot_done !== 1'b1) tick();
        tick();
        chk_byte({7'h0, req_ready}, 8'h01);
        chk_byte({7'h0, dev.armed}, 8'h01);
        $display("test boot done");
    endtask
    // reserved direction read across the top of the address space
    task automatic t_rd;
        xfer(0, 0, 2'h1, 14'h3fff, 2);
        chk_byte(rb[0], 8'ha5);
        chk_byte(rb[1], 8'h5a);
        chk_byte(dev.frame_bits, 8'd48);
        $display("test rd done");
    endtask
    task automatic t_wr_rd(input logic m3, input logic [1:0] d, input logic [13:0] a);
        logic [13:0] p;
        xfer(1, m3, d, a, 3);
        chk_byte(dev.frame_bits, 8'd48);
        chk_byte(dev.cmd, 8'h02);
        p = a;
        for (int i = 0; i < 3; i++) begin
            chk_byte(dev.mem[p], d == 2'h3 ? wb[2] : wb[i]);
            p = d == 2'h2 ? p - 14'h1 : (d == 2'h3 ? p : p + 14'h1);
        end
        xfer(0, !m3, d, a, 3);
        chk_byte(dev.frame_bits, 8'd56);
        chk_byte(dev.cmd, 8'h0b);
        for (int i = 0; i < 3; i++) chk_byte(rb[i], d == 2'h3 ? wb[2] : wb[i]);
        $display("test wr_rd dir=%h addr=%h done", d, a);
    endtask
    // clear-on-read byte: old value comes out, an event during the read survives
    task automatic t_cor;
        xfer(1, 0, 2'h3, 14'h2000, 1);
        fork
            xfer(0, 0, 2'h0, 14'h2000, 2);
            begin
                while (dev.cor_pend !== 1'b1) tick();
                tick();
                evt = 1;
                tick();
                evt = 0;
            end
        join
        chk_byte(rb[0], 8'hc1);
        chk_byte(rb[1], 8'h5b);
        chk_byte(dev.mem[14'h2000], 8'h01);
        $display("test cor done");
    endtask
    initial begin
        repeat (3) @(posedge clk);
        #2 rst_n = 1;
        t_boot();
        t_rd();
        t_wr_rd(0, 2'h0, 14'h3ffe);
        t_wr_rd(1, 2'h2, 14'h0001);
        t_wr_rd(0, 2'h3, 14'h0100);
        t_wr_rd(1, 2'h1, 14'h0200);
        t_cor();
        report_and_stop();
    end
    initial begin
        #1000000;
        err_count++;
        report_and_stop();
    end
endmodule
